// ==== rtl/fdc_param_map.svh ====
// Constant map for the floppy command parameter decode block
`ifndef FDC_PARAM_MAP_SVH
`define FDC_PARAM_MAP_SVH
`define SZ_BASE_BYTES     17'h00080
`define SZ_CODE_MAX       3'h7
`define STEP_UNIT_US      500
`define CLK_MHZ           100
`define STEP_UNIT_CYC     (`STEP_UNIT_US * `CLK_MHZ)
`define TRK_MIN           8'h00
`define TRK_MAX           8'hFF
`define PERP_LOW_BITS     4
`define FIFO_EN_RST       1'h1
`define FIFO_THR_RST      4'h0
`define PRECOMP_START_TRACK_RST        8'h00
`define CYL_RST           8'h00
`define STAT_RST          8'h00
`define PRE_ERASE_CYC     8'h04
`define STEP_PULSE_CYC    16'h0064
`endif

// ==== rtl/fdc_param_pkg.sv ====
// Types for the floppy command parameter decode block
package fdc_param_pkg;
   typedef struct packed {
      logic [7:0] cmd;
      logic [7:0] target_cylinder;
      logic [7:0] relative_cylinder;
      logic [7:0] sector;
      logic [2:0] size_code;
      logic [7:0] sectors_per_track;
      logic       verify_count_enable;
      logic       skip_deleted_flag;
      logic       density_select;
      logic       no_dma_flag;
      logic [3:0] step_interval;
      logic [3:0] perp_low;
      logic       write_gate_timing;
   } cmd_params_s;
   typedef struct packed {
      logic [7:0] status_byte_zero;
      logic [7:0] status_byte_one;
      logic [7:0] status_byte_two;
      logic [7:0] status_byte_three;
   } result_s;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_EXEC = 3'b010,
      ST_RES  = 3'b100
   } phase_e;
   typedef enum logic [1:0] {
      OP_RD  = 2'h0,
      OP_RDD = 2'h1,
      OP_WR  = 2'h2,
      OP_FMT = 2'h3
   } op_e;
endpackage

// ==== rtl/byte_buf2.sv ====
// Two-entry valid/ready buffer for the data byte stream
`timescale 1ns/100ps
module byte_buf2 #(
   parameter int W = 8
) (
   input  wire logic         i_clk,
   input  wire logic         i_rst_n,
   input  wire logic         i_valid,
   output logic              o_ready,
   input  wire logic [W-1:0] i_data,
   output logic              o_valid,
   input  wire logic         i_ready,
   output logic [W-1:0]      o_data
);
   initial begin
      if (W < 1) $error("byte_buf2 width must be positive");
   end
   // ==================================================
   // Storage
   logic [W-1:0] mem_q [2];
   logic [W-1:0] mem_d [2];
   logic         wp_q, wp_d, rp_q, rp_d;
   logic [1:0]   cnt_q, cnt_d;
   logic         push, pop;
   // Next state; full stalls the source so nothing is dropped
   always_comb begin
      push  = i_valid && (cnt_q != 2'h2);
      pop   = i_ready && (cnt_q != 2'h0);
      mem_d = mem_q;
      if (push) begin
         mem_d[wp_q] = i_data;
      end
      wp_d  = push ? ~wp_q : wp_q;
      rp_d  = pop ? ~rp_q : rp_q;
      cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
   end
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         mem_q[0] <= '0;
         mem_q[1] <= '0;
         wp_q     <= 1'b0;
         rp_q     <= 1'b0;
         cnt_q    <= 2'h0;
      end else begin
         mem_q <= mem_d;
         wp_q  <= wp_d;
         rp_q  <= rp_d;
         cnt_q <= cnt_d;
      end
   end
   assign o_ready = (cnt_q != 2'h2);
   assign o_valid = (cnt_q != 2'h0);
   assign o_data  = mem_q[rp_q];
endmodule

// ==== rtl/fdc_param_decode.sv ====
// Command parameter decode and execution-phase control for the disk controller
`timescale 1ns/100ps
`include "fdc_param_map.svh"
module fdc_param_decode #(
   parameter int STEP_UNIT_CYCLES = `STEP_UNIT_CYC
) (
   input  wire logic                      I_CORE_CLK,
   input  wire logic                      I_RESET_N,
   input  wire logic                      I_CMD_LOAD,
   input  wire fdc_param_pkg::cmd_params_s I_CMD,
   input  wire logic [1:0]                I_OP,
   input  wire logic                      I_SEEK,
   input  wire logic                      I_REL_SEEK,
   input  wire logic                      I_REL_DIR_OUT,
   input  wire logic                      I_SENSE_INT,
   input  wire logic                      I_PERP_WRITE,
   input  wire logic                      I_LOCK_WRITE,
   input  wire logic                      I_LOCK_VAL,
   input  wire logic                      I_OVERWRITE_PERMIT,
   input  wire logic                      I_CFG_WRITE,
   input  wire logic                      I_FIFO_ENABLE_CFG,
   input  wire logic [3:0]                I_FIFO_THRESHOLD_CFG,
   input  wire logic [7:0]                I_PRECOMP_START_TRACK,
   input  wire logic                      I_SOFT_RESET,
   input  wire logic                      I_POLL_DISABLE,
   input  wire logic                      I_SECTOR_DONE,
   input  wire logic                      I_SECTOR_DELETED,
   input  wire logic                      I_DISK_VALID,
   input  wire logic [7:0]                I_DISK_DATA,
   input  wire logic                      I_TRANSFER_ACKNOWLEDGE_N,
   input  wire logic                      I_HOST_TAKE,
   input  wire fdc_param_pkg::result_s    I_RESULT,
   input  wire logic                      I_RESULT_LOAD,
   input  wire logic                      I_WRITE_REQ,
   output logic                           O_DISK_READY,
   output logic                           O_TRANSFER_REQUEST,
   output logic                           O_BYTE_IRQ,
   output logic [7:0]                     O_HOST_DATA,
   output logic [16:0]                    O_SECTOR_BYTES,
   output logic [7:0]                     O_SECTOR_NOW,
   output logic                           O_SECTOR_ACCEPT,
   output logic [7:0]                     O_CURRENT_CYLINDER,
   output logic                           O_STEP,
   output logic                           O_DIR_OUT,
   output logic                           O_POLL_RUN,
   output logic [3:0]                     O_PERP_LOW,
   output logic                           O_DENSITY_SELECT,
   output logic                           O_WRITE_ENABLE,
   output logic                           O_FIFO_ENABLE_CFG,
   output logic [3:0]                     O_FIFO_THRESHOLD_CFG,
   output logic [7:0]                     O_PRECOMP_START_TRACK,
   output fdc_param_pkg::result_s         O_RESULT,
   output logic                           O_BUSY
);
   // Two cycles at least, so a step pulse can never stand two cycles
   if (STEP_UNIT_CYCLES < 2) begin : g_unit_chk
      $error("step unit must be at least two cycles");
   end
   // ==================================================
   // Size decode for the registered sector length
   function automatic logic [16:0] size_bytes(input logic [2:0] code);
      size_bytes = `SZ_BASE_BYTES << code;
   endfunction
   // ==================================================
   // Data path buffer: a host stall holds the disk side off
   logic       bv, br;
   logic [7:0] bd;
   logic       buf_in_ready;
   byte_buf2 #(.W(8)) byte_buf2_i (
      .i_clk   (I_CORE_CLK),
      .i_rst_n (I_RESET_N),
      .i_valid (I_DISK_VALID),
      .o_ready (buf_in_ready),
      .i_data  (I_DISK_DATA),
      .o_valid (bv),
      .i_ready (br),
      .o_data  (bd)
   );
   // ==================================================
   // State
   fdc_param_pkg::phase_e      ph_q, ph_d;
   fdc_param_pkg::cmd_params_s prm_q, prm_d;
   fdc_param_pkg::result_s     res_q, res_d;
   logic [1:0]  op_q, op_d;
   logic [7:0]  cyl_q, cyl_d, tgt_q, tgt_d, sec_q, sec_d, left_q, left_d;
   logic [7:0]  rpt_cyl_q, rpt_cyl_d;
   logic [31:0] stc_q, stc_d;
   logic [15:0] pw_q, pw_d;
   logic        dir_q, dir_d, step_q, step_d;
   logic [3:0]  perp_q, perp_d;
   logic        ow_q, ow_d, lock_q, lock_d;
   logic        fen_q, fen_d;
   logic [3:0]  fthr_q, fthr_d;
   logic [7:0]  ptrk_q, ptrk_d;
   logic        drq_q, drq_d, irq_q, irq_d, hv_q, hv_d;
   logic [7:0]  hd_q, hd_d;
   logic [7:0]  wgc_q, wgc_d;
   logic        we_q, we_d, acc_q, acc_d, poll_q, poll_d;
   logic        moving;
   logic [31:0] step_cycles;
   logic        ack;
   // Next values for all control state but the size, ready and busy flops
   always_comb begin
      ph_d = ph_q; prm_d = prm_q; res_d = res_q; op_d = op_q;
      cyl_d = cyl_q; tgt_d = tgt_q; sec_d = sec_q; left_d = left_q;
      rpt_cyl_d = rpt_cyl_q; stc_d = stc_q; pw_d = pw_q;
      dir_d = dir_q; step_d = 1'b0; perp_d = perp_q; ow_d = ow_q;
      lock_d = lock_q; fen_d = fen_q; fthr_d = fthr_q; ptrk_d = ptrk_q;
      drq_d = drq_q; irq_d = 1'b0; hv_d = hv_q; hd_d = hd_q;
      wgc_d = wgc_q; we_d = 1'b0; acc_d = 1'b0;
      poll_d = ~I_POLL_DISABLE;
      ack = ~I_TRANSFER_ACKNOWLEDGE_N;
      br = 1'b0;
      step_cycles = ({28'h0, prm_q.step_interval} + 32'h1) * STEP_UNIT_CYCLES;
      moving = (cyl_q != tgt_q);
      // Parameters frozen once taken, new loads ignored until idle
      case (ph_q)
         fdc_param_pkg::ST_IDLE: begin
            if (I_CMD_LOAD) begin
               prm_d  = I_CMD;
               op_d   = I_OP;
               sec_d  = I_CMD.sector;
               left_d = I_CMD.sectors_per_track;
               wgc_d  = `PRE_ERASE_CYC;
               ph_d   = fdc_param_pkg::ST_EXEC;
            end
         end
         fdc_param_pkg::ST_EXEC: begin
            // Byte path: DMA handshake or per-byte interrupt
            if (prm_q.no_dma_flag) begin
               if (bv && !hv_q) begin
                  hd_d = bd; hv_d = 1'b1; br = 1'b1;
                  irq_d = 1'b1;
               end
               if (hv_q && I_HOST_TAKE) hv_d = 1'b0;
            end else begin
               drq_d = bv;
               if (drq_q && ack && bv) begin
                  hd_d = bd; br = 1'b1;
                  drq_d = 1'b0;
               end
            end
            if (I_SECTOR_DONE) begin
               // Sector acceptance by skip mode
               if (prm_q.skip_deleted_flag && op_q == fdc_param_pkg::OP_RD)
                  acc_d = ~I_SECTOR_DELETED;
               else if (prm_q.skip_deleted_flag &&
                        op_q == fdc_param_pkg::OP_RDD)
                  acc_d = I_SECTOR_DELETED;
               else
                  acc_d = 1'b1;
               sec_d  = sec_q + 8'h01;
               left_d = left_q - 8'h01;
               if (left_q == 8'h01 && (op_q == fdc_param_pkg::OP_FMT ||
                   prm_q.verify_count_enable))
                  ph_d = fdc_param_pkg::ST_RES;
            end
            // Write gate lead before write enable
            if (I_WRITE_REQ) begin
               if (prm_q.write_gate_timing && wgc_q != 8'h00)
                  wgc_d = wgc_q - 8'h01;
               else
                  we_d = 1'b1;
            end
            if (I_RESULT_LOAD) begin
               res_d = I_RESULT;
               ph_d  = fdc_param_pkg::ST_RES;
            end
         end
         fdc_param_pkg::ST_RES: begin
            drq_d = 1'b0;
            hv_d  = 1'b0;
            if (I_RESULT_LOAD) res_d = I_RESULT;
            if (I_HOST_TAKE) ph_d = fdc_param_pkg::ST_IDLE;
         end
         default: ph_d = fdc_param_pkg::ST_IDLE;
      endcase
      // Seek targets
      if (I_SEEK) tgt_d = I_CMD.target_cylinder;
      if (I_REL_SEEK) begin
         dir_d = I_REL_DIR_OUT;
         tgt_d = I_REL_DIR_OUT ? cyl_q + I_CMD.relative_cylinder
                               : cyl_q - I_CMD.relative_cylinder;
      end
      // Stepper: one pulse per interval, count restarts per pulse
      if (moving) begin
         if (!I_SEEK && !I_REL_SEEK) dir_d = (tgt_q > cyl_q);
         if (stc_q >= step_cycles - 32'h1) begin
            stc_d = 32'h0;
            step_d = 1'b1;
            cyl_d = (tgt_q > cyl_q) ? cyl_q + 8'h01 : cyl_q - 8'h01;
         end else begin
            stc_d = stc_q + 32'h1;
         end
      end else begin
         stc_d = 32'h0;
      end
      pw_d = pw_q;
      if (I_SENSE_INT) rpt_cyl_d = cyl_q;
      if (I_LOCK_WRITE) begin
         lock_d = I_LOCK_VAL;
         ow_d   = I_OVERWRITE_PERMIT;
      end
      if (I_PERP_WRITE && ow_q) perp_d = I_CMD.perp_low;
      if (I_CFG_WRITE) begin
         fen_d  = I_FIFO_ENABLE_CFG;
         fthr_d = I_FIFO_THRESHOLD_CFG;
         ptrk_d = I_PRECOMP_START_TRACK;
      end
      if (I_SOFT_RESET && !lock_q) begin
         fen_d  = `FIFO_EN_RST;
         fthr_d = `FIFO_THR_RST;
         ptrk_d = `PRECOMP_START_TRACK_RST;
      end
   end
   // Registering only
   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RESET_N) begin
         ph_q <= fdc_param_pkg::ST_IDLE; prm_q <= '0; res_q <= '0;
         op_q <= 2'h0; cyl_q <= `CYL_RST; tgt_q <= `CYL_RST;
         sec_q <= 8'h00; left_q <= 8'h00; rpt_cyl_q <= `CYL_RST;
         stc_q <= 32'h0; pw_q <= 16'h0000; dir_q <= 1'b0; step_q <= 1'b0;
         perp_q <= 4'h0; ow_q <= 1'b0; lock_q <= 1'b0;
         fen_q <= `FIFO_EN_RST; fthr_q <= `FIFO_THR_RST;
         ptrk_q <= `PRECOMP_START_TRACK_RST; drq_q <= 1'b0; irq_q <= 1'b0;
         hv_q <= 1'b0; hd_q <= 8'h00; wgc_q <= 8'h00; we_q <= 1'b0;
         acc_q <= 1'b0; poll_q <= 1'b0;
      end else begin
         ph_q <= ph_d; prm_q <= prm_d; res_q <= res_d; op_q <= op_d;
         cyl_q <= cyl_d; tgt_q <= tgt_d; sec_q <= sec_d; left_q <= left_d;
         rpt_cyl_q <= rpt_cyl_d; stc_q <= stc_d; pw_q <= pw_d;
         dir_q <= dir_d; step_q <= step_d; perp_q <= perp_d; ow_q <= ow_d;
         lock_q <= lock_d; fen_q <= fen_d; fthr_q <= fthr_d;
         ptrk_q <= ptrk_d; drq_q <= drq_d; irq_q <= irq_d; hv_q <= hv_d;
         hd_q <= hd_d; wgc_q <= wgc_d; we_q <= we_d; acc_q <= acc_d;
         poll_q <= poll_d;
      end
   end
   // Registered size, ready and busy keep outputs flop-driven; ready
   // looks one word ahead, since a late full flag would drop a word
   logic [16:0] sz_q;
   logic        rdy_q;
   logic        busy_q;
   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RESET_N) begin
         sz_q   <= `SZ_BASE_BYTES;
         rdy_q  <= 1'b0;
         busy_q <= 1'b0;
      end else begin
         sz_q   <= size_bytes(prm_d.size_code);
         rdy_q  <= br || (buf_in_ready && !(bv && I_DISK_VALID));
         busy_q <= (ph_d != fdc_param_pkg::ST_IDLE);
      end
   end
   // ==================================================
   // Outputs
   assign O_DISK_READY          = rdy_q;
   assign O_TRANSFER_REQUEST    = drq_q;
   assign O_BYTE_IRQ            = irq_q;
   assign O_HOST_DATA           = hd_q;
   assign O_SECTOR_BYTES        = sz_q;
   assign O_SECTOR_NOW          = sec_q;
   assign O_SECTOR_ACCEPT       = acc_q;
   assign O_CURRENT_CYLINDER    = rpt_cyl_q;
   assign O_STEP                = step_q;
   assign O_DIR_OUT             = dir_q;
   assign O_POLL_RUN            = poll_q;
   assign O_PERP_LOW            = perp_q;
   assign O_DENSITY_SELECT      = prm_q.density_select;
   assign O_WRITE_ENABLE        = we_q;
   assign O_FIFO_ENABLE_CFG     = fen_q;
   assign O_FIFO_THRESHOLD_CFG  = fthr_q;
   assign O_PRECOMP_START_TRACK = ptrk_q;
   assign O_RESULT              = res_q;
   assign O_BUSY                = busy_q;
endmodule

// ==== verif/fdc_param_decode_chk.sv ====
// Port-level assertions for the command parameter decode block
`timescale 1ns/100ps
module fdc_param_decode_chk #(
   parameter int STEP_UNIT_CYCLES = 50000
) (
   input wire logic                       I_CORE_CLK,
   input wire logic                       I_RESET_N,
   input wire logic                       I_CMD_LOAD,
   input wire fdc_param_pkg::cmd_params_s I_CMD,
   input wire logic                       I_SENSE_INT,
   input wire logic                       I_PERP_WRITE,
   input wire logic                       I_LOCK_WRITE,
   input wire logic                       I_LOCK_VAL,
   input wire logic                       I_OVERWRITE_PERMIT,
   input wire logic                       I_SOFT_RESET,
   input wire logic                       I_POLL_DISABLE,
   input wire logic                       I_SECTOR_DONE,
   input wire fdc_param_pkg::result_s     I_RESULT,
   input wire logic                       I_RESULT_LOAD,
   input wire logic                       O_TRANSFER_REQUEST,
   input wire logic                       O_BYTE_IRQ,
   input wire logic [16:0]                O_SECTOR_BYTES,
   input wire logic                       O_SECTOR_ACCEPT,
   input wire logic [7:0]                 O_CURRENT_CYLINDER,
   input wire logic                       O_STEP,
   input wire logic                       O_POLL_RUN,
   input wire logic [3:0]                 O_PERP_LOW,
   input wire logic                       O_DENSITY_SELECT,
   input wire logic                       O_FIFO_ENABLE_CFG,
   input wire logic [3:0]                 O_FIFO_THRESHOLD_CFG,
   input wire logic [7:0]                 O_PRECOMP_START_TRACK,
   input wire fdc_param_pkg::result_s     O_RESULT,
   input wire logic                       O_BUSY
);
   logic lock_q;
   logic lock_d;
   logic perm_q;
   logic perm_d;
   // =====================================================
   // Mirror of lock settings, so checks need no internals
   always_comb begin
      lock_d = I_LOCK_WRITE ? I_LOCK_VAL : lock_q;
      perm_d = I_LOCK_WRITE ? I_OVERWRITE_PERMIT : perm_q;
   end
   always_ff @(posedge I_CORE_CLK) begin
      lock_q <= I_RESET_N & lock_d;
      perm_q <= I_RESET_N & perm_d;
   end
   // =====================================================
   // Assertions
   default clocking cb @(posedge I_CORE_CLK); endclocking
   default disable iff (!I_RESET_N);
   sequence s_take;
      I_CMD_LOAD && !O_BUSY;
   endsequence
   sequence s_perp_try;
      I_PERP_WRITE && !I_LOCK_WRITE;
   endsequence
   chk_size_decode: assert property (s_take |=> O_BUSY &&
      O_SECTOR_BYTES == (17'h00080 << $past(I_CMD.size_code)))
      else $error("sector length does not match size code");
   chk_density_take: assert property (s_take |=>
      O_DENSITY_SELECT == $past(I_CMD.density_select))
      else $error("density select not taken from command");
   chk_busy_hold: assert property (O_BUSY && I_CMD_LOAD |=>
      $stable(O_SECTOR_BYTES) && $stable(O_DENSITY_SELECT))
      else $error("parameters changed during execution");
   chk_perp_refuse: assert property (s_perp_try and !perm_q |=>
      $stable(O_PERP_LOW)) else $error("perpendicular bits changed");
   chk_perp_update: assert property (s_perp_try and perm_q |=>
      O_PERP_LOW == $past(I_CMD.perp_low))
      else $error("perpendicular bits not written");
   chk_poll_follow: assert property ($past(I_RESET_N) |->
      O_POLL_RUN == !$past(I_POLL_DISABLE)) else $error("poll run wrong");
   chk_cyl_hold: assert property (!I_SENSE_INT |=>
      $stable(O_CURRENT_CYLINDER)) else $error("cylinder report moved");
   chk_step_single: assert property (O_STEP |=> !O_STEP)
      else $error("step pulse longer than one cycle");
   chk_irq_single: assert property (O_BYTE_IRQ |=> !O_BYTE_IRQ)
      else $error("byte interrupt longer than one cycle");
   chk_mode_excl: assert property (
      !(O_BYTE_IRQ && O_TRANSFER_REQUEST))
      else $error("interrupt and transfer request together");
   chk_accept_cause: assert property (O_SECTOR_ACCEPT |->
      $past(I_SECTOR_DONE)) else $error("accept without sector");
   chk_result_load: assert property (I_RESULT_LOAD |=>
      O_RESULT == $past(I_RESULT)) else $error("status bytes not held");
   chk_soft_default: assert property (I_SOFT_RESET && !lock_q
      && !I_LOCK_WRITE |=> O_FIFO_ENABLE_CFG && O_FIFO_THRESHOLD_CFG
      == 4'h0 && O_PRECOMP_START_TRACK == 8'h00)
      else $error("config not restored by soft reset");
endmodule
bind fdc_param_decode fdc_param_decode_chk #(
   .STEP_UNIT_CYCLES(STEP_UNIT_CYCLES)
) fdc_param_decode_chk_i (.I_CORE_CLK, .I_RESET_N, .I_CMD_LOAD, .I_CMD,
   .I_SENSE_INT, .I_PERP_WRITE, .I_LOCK_WRITE, .I_LOCK_VAL,
   .I_OVERWRITE_PERMIT, .I_SOFT_RESET, .I_POLL_DISABLE, .I_SECTOR_DONE,
   .I_RESULT, .I_RESULT_LOAD, .O_TRANSFER_REQUEST, .O_BYTE_IRQ,
   .O_SECTOR_BYTES, .O_SECTOR_ACCEPT, .O_CURRENT_CYLINDER, .O_STEP,
   .O_POLL_RUN, .O_PERP_LOW, .O_DENSITY_SELECT, .O_FIFO_ENABLE_CFG,
   .O_FIFO_THRESHOLD_CFG, .O_PRECOMP_START_TRACK, .O_RESULT, .O_BUSY);

// ==== verif/dma_host_model.sv ====
// Host and DMA controller model on the far side of the data path
`timescale 1ns/100ps
module dma_host_model (
   input  wire logic       i_clk,
   input  wire logic       i_rst_n,
   input  wire logic       i_req,
   input  wire logic       i_irq,
   input  wire logic [7:0] i_data,
   input  wire logic       i_stall,
   output logic            o_ack_n,
   output logic            o_take,
   output logic            o_got,
   output logic [7:0]      o_byte
);
   initial begin
      o_ack_n = 1'b1;
      o_take = 1'b0;
      o_got = 1'b0;
   end
   // Ack held low until request drops; stall shows a slow controller
   always @(posedge i_clk) begin
      o_take <= i_irq; // One host read per interrupt
      o_got <= i_irq || (i_rst_n && !o_ack_n && !i_req);
      o_byte <= i_data;
      if (!i_rst_n) begin
         o_ack_n <= 1'b1;
      end else if (!o_ack_n && !i_req) begin
         o_ack_n <= 1'b1; // Byte handed over
      end else if (i_req && !i_stall) begin
         o_ack_n <= 1'b0; // Serve request
      end
   end
endmodule

// ==== verif/tb_fdc_param_decode.sv ====
// Self-checking bench for the command parameter decode block
`timescale 1ns/100ps
`include "fdc_param_map.svh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin failures++; \
   $display("Error %0t got %h exp %h", $time, (a), (e)); end end
module tb_fdc_param_decode;
   localparam int SU = 2;
   typedef struct {logic [2:0] sz; logic dn; logic [16:0] by;} row_s;
   row_s rows [8] = '{'{3'h0, 1'b1, 17'h00080}, '{3'h1, 1'b0, 17'h00100},
      '{3'h2, 1'b1, 17'h00200}, '{3'h3, 1'b0, 17'h00400},
      '{3'h4, 1'b1, 17'h00800}, '{3'h5, 1'b0, 17'h01000},
      '{3'h6, 1'b1, 17'h02000}, '{3'h7, 1'b0, 17'h04000}};
   logic clk = 1'b0, rst_n = 1'b0, load = 1'b0, seek = 1'b0, rseek = 1'b0;
   logic rdir = 1'b0, sense = 1'b0, perp = 1'b0, lockw = 1'b0, lockv = 1'b0;
   logic permit = 1'b0, cfgw = 1'b0, fen = 1'b0, srst = 1'b0, pdis = 1'b0;
   logic sdone = 1'b0, sdel = 1'b0, dval = 1'b0, htake = 1'b0, wreq = 1'b0;
   logic rload = 1'b0, stall = 1'b0, ack_n, mtake, got;
   logic [1:0] op = 2'h0;
   logic [3:0] fthr = 4'h0, plow, fthr_o;
   logic [7:0] ptrk = 8'h00, ddata = 8'h00, hdata, snow, cyl, ptrk_o;
   logic [7:0] gbyte, n, qexp;
   logic [16:0] sbytes;
   logic dready, req, irq, sacc, step, dirout, prun, dens, we, fen_o, busy;
   fdc_param_pkg::cmd_params_s cmd = '0;
   fdc_param_pkg::result_s     result = 32'h3C5A_9617, res_o;
   int failures = 0, n_tests = 0, nsteps = 0, gap = 0, last = 0, cyc = 0;
   int nirq = 0;
   logic [7:0] expq [$];
   // =====================================================
   // Clock, design and far-side model
   always #5 clk = ~clk;
   fdc_param_decode #(.STEP_UNIT_CYCLES(SU)) fdc_param_decode_i (
      .I_CORE_CLK(clk), .I_RESET_N(rst_n), .I_CMD_LOAD(load), .I_CMD(cmd),
      .I_OP(op), .I_SEEK(seek), .I_REL_SEEK(rseek), .I_REL_DIR_OUT(rdir),
      .I_SENSE_INT(sense), .I_PERP_WRITE(perp), .I_LOCK_WRITE(lockw),
      .I_LOCK_VAL(lockv), .I_OVERWRITE_PERMIT(permit), .I_CFG_WRITE(cfgw),
      .I_FIFO_ENABLE_CFG(fen), .I_FIFO_THRESHOLD_CFG(fthr),
      .I_PRECOMP_START_TRACK(ptrk), .I_SOFT_RESET(srst),
      .I_POLL_DISABLE(pdis), .I_SECTOR_DONE(sdone), .I_SECTOR_DELETED(sdel),
      .I_DISK_VALID(dval), .I_DISK_DATA(ddata),
      .I_TRANSFER_ACKNOWLEDGE_N(ack_n), .I_HOST_TAKE(mtake | htake),
      .I_RESULT(result), .I_RESULT_LOAD(rload), .I_WRITE_REQ(wreq),
      .O_DISK_READY(dready), .O_TRANSFER_REQUEST(req), .O_BYTE_IRQ(irq),
      .O_HOST_DATA(hdata), .O_SECTOR_BYTES(sbytes), .O_SECTOR_NOW(snow),
      .O_SECTOR_ACCEPT(sacc), .O_CURRENT_CYLINDER(cyl), .O_STEP(step),
      .O_DIR_OUT(dirout), .O_POLL_RUN(prun), .O_PERP_LOW(plow),
      .O_DENSITY_SELECT(dens), .O_WRITE_ENABLE(we),
      .O_FIFO_ENABLE_CFG(fen_o), .O_FIFO_THRESHOLD_CFG(fthr_o),
      .O_PRECOMP_START_TRACK(ptrk_o), .O_RESULT(res_o), .O_BUSY(busy));
   dma_host_model dma_host_model_i (.i_clk(clk), .i_rst_n(rst_n),
      .i_req(req), .i_irq(irq), .i_data(hdata), .i_stall(stall),
      .o_ack_n(ack_n), .o_take(mtake), .o_got(got), .o_byte(gbyte));
   // Step spacing, interrupt count and delivered byte order
   always @(posedge clk) begin
      cyc++;
      if (step) begin nsteps++; gap = cyc - last; last = cyc; end
      if (irq) nirq++;
      if (got) begin
         qexp = expq.pop_front();
         `CHK(gbyte, qexp)
      end
   end
   // =====================================================
   // Tasks; every wait ends 1 ns past an edge
   task automatic tk(int c); repeat (c) @(posedge clk); #1; endtask
   task automatic done(string s); $display("Test %s done", s); endtask
   task automatic start(logic [1:0] o);
      op <= o; load <= 1'b1; tk(1); load <= 1'b0;
      `CHK(busy, 1'b1)
   endtask
   task automatic close_cmd();
      result <= ~result; rload <= 1'b1; tk(1); rload <= 1'b0;
      `CHK(res_o, result)
      htake <= 1'b1; tk(1); htake <= 1'b0; tk(1);
      `CHK(busy, 1'b0)
   endtask
   task automatic push(logic [7:0] b);
      dval <= 1'b1; ddata <= b; expq.push_back(b); tk(1);
      dval <= 1'b0; ddata <= ~b; tk(1);
   endtask
   task automatic results();
      $display("Comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // Watchdog, generous against about 300 cycles of tests
   initial begin repeat (20000) @(posedge clk); failures++; results(); end
   // =====================================================
   // Main sequence
   initial begin
      cmd.step_interval <= 4'h1; tk(10); rst_n <= 1'b1;
      foreach (rows[i]) begin
         cmd.size_code <= rows[i].sz; cmd.density_select <= rows[i].dn;
         start(fdc_param_pkg::OP_RD);
         `CHK(sbytes, rows[i].by)
         `CHK(dens, rows[i].dn)
         cmd.size_code <= ~rows[i].sz; tk(1); load <= 1'b1; tk(1);
         load <= 1'b0; tk(1); `CHK(sbytes, rows[i].by)
         close_cmd();
      end
      done("size rows");
      cmd.target_cylinder <= 8'h05; nsteps = 0;
      seek <= 1'b1; tk(1); seek <= 1'b0; tk(40);
      `CHK(nsteps, 5)
      `CHK(gap, 2 * SU)
      `CHK(dirout, 1'b1)
      sense <= 1'b1; tk(1); sense <= 1'b0; tk(1); `CHK(cyl, 8'h05)
      cmd.relative_cylinder <= 8'h02; rdir <= 1'b0; nsteps = 0;
      rseek <= 1'b1; tk(1); rseek <= 1'b0; tk(40);
      `CHK({nsteps[7:0], dirout}, {8'h02, 1'b0})
      sense <= 1'b1; tk(1); sense <= 1'b0; tk(1); `CHK(cyl, 8'h03)
      done("seek");
      cmd.perp_low <= 4'hA; cmd.sector <= 8'h11;
      for (int p = 0; p < 2; p++) begin
         permit <= p[0]; lockw <= 1'b1; tk(1); lockw <= 1'b0;
         perp <= 1'b1; tk(1); perp <= 1'b0; tk(1);
         `CHK(plow, p ? 4'hA : 4'h0)
      end
      fthr <= 4'hF; ptrk <= 8'hFF;
      for (int l = 0; l < 2; l++) begin
         lockv <= l[0]; lockw <= 1'b1; tk(1); lockw <= 1'b0;
         cfgw <= 1'b1; tk(1); cfgw <= 1'b0; tk(1);
         `CHK(ptrk_o, 8'hFF)
         srst <= 1'b1; tk(1); srst <= 1'b0; tk(1);
         `CHK({fen_o, fthr_o, ptrk_o}, l ? 13'h0FFF : 13'h1000)
      end
      pdis <= 1'b1; tk(2); `CHK(prun, 1'b0)
      pdis <= 1'b0; tk(2); `CHK(prun, 1'b1)
      done("config");
      for (int k = 0; k < 4; k++) begin
         cmd.skip_deleted_flag <= k[0];
         start(k[1] ? fdc_param_pkg::OP_RDD : fdc_param_pkg::OP_RD);
         for (int d = 0; d < 2; d++) begin
            sdone <= 1'b1; sdel <= d[0]; tk(1); sdone <= 1'b0;
            `CHK(sacc, !k[0] || (d[0] == k[1]))
            tk(1);
         end
         `CHK(snow, 8'h13)
         close_cmd();
      end
      cmd.sectors_per_track <= 8'h02; start(fdc_param_pkg::OP_FMT);
      repeat (2) begin
         sdone <= 1'b1; tk(1); sdone <= 1'b0; tk(1);
      end
      htake <= 1'b1; tk(1); htake <= 1'b0; tk(1);
      `CHK(busy, 1'b0)
      done("skip");
      cmd.no_dma_flag <= 1'b0; stall <= 1'b1; start(fdc_param_pkg::OP_RD);
      for (int b = 0; b < 6 && dready; b++) push(8'h5A + 8'(b));
      `CHK({dready, req}, 2'b01)
      stall <= 1'b0; tk(40); `CHK(expq.size(), 0)
      close_cmd();
      cmd.no_dma_flag <= 1'b1; start(fdc_param_pkg::OP_RD); nirq = 0;
      for (int b = 0; b < 3; b++) push(8'hC3 ^ 8'(b));
      tk(10); `CHK({nirq[7:0], req}, {8'h03, 1'b0})
      `CHK(expq.size(), 0)
      close_cmd();
      done("transfer");
      cmd.write_gate_timing <= 1'b1; start(fdc_param_pkg::OP_WR);
      wreq <= 1'b1;
      for (n = 8'h00; n < 8'h0C && we !== 1'b1; n++) tk(1);
      `CHK(n, `PRE_ERASE_CYC + 8'h01)
      wreq <= 1'b0; close_cmd();
      rst_n <= 1'b0; tk(2); rst_n <= 1'b1; tk(1);
      `CHK(sbytes, 17'h00080)
      `CHK({fen_o, busy, step, cyl}, {3'b100, 8'h00})
      done("reset");
      results();
   end
endmodule
